// File: rtl/bridge_consts.svh
// offsets, reset values, decode constants and timing counts of the bridge
// assumes a 125 MHz clk_i; included by its bare name
`ifndef BRIDGE_CONSTS_SVH
`define BRIDGE_CONSTS_SVH
`define CLK_MHZ        125
`define REG_CTRL       8'h00
`define REG_IRQ_EN     8'h04
`define REG_RGN0       8'h08
`define REG_RGN1       8'h0C
`define REG_RGN2       8'h10
`define REG_STATUS     8'h14
`define CTRL_RST       16'h0983
`define CTRL_COMA_EN   0
`define CTRL_COMB_EN   1
`define CTRL_COMA_LSB  4
`define CTRL_COMB_LSB  8
`define CTRL_MEM_EN    12
`define RGN_EN         31
`define RGN_MASK_LSB   16
`define OWN_LO         16'h0C80
`define OWN_HI         16'h0CBF
`define MEM_LO         20'hD0000
`define MEM_HI         20'hDFFFF
`define COM_BASE_0     16'h0200
`define COM_BASE_1     16'h0208
`define COM_BASE_2     16'h0220
`define COM_BASE_3     16'h0228
`define COM_BASE_4     16'h0238
`define COM_BASE_5     16'h02E8
`define COM_BASE_6     16'h0338
`define COM_BASE_7     16'h03E8
`define COM_BASE_8     16'h03F8
`define COM_BASE_9     16'h02F8
`define ADDR_NS        100
`define CMD_NS         500
`define REC_NS         200
`define ADDR_CYC       8'(((`ADDR_NS * `CLK_MHZ) + 999) / 1000)
`define CMD_CYC        8'(((`CMD_NS * `CLK_MHZ) + 999) / 1000)
`define REC_CYC        8'(((`REC_NS * `CLK_MHZ) + 999) / 1000)
`endif

// File: rtl/bridge_pkg.sv
// types shared by the bridge
// assumes nothing beyond the constants header
package bridge_pkg;
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_CMD, S_RECOV} state_t;
    typedef logic [9:0] irq_vec_t;
endpackage

// File: rtl/lpc_isa_bridge.sv
// host-to-ISA bridge: decode, ISA master cycles, irq gating, wishbone regs
// assumes host requests and wishbone on clk_i, ISA pins asynchronous
// Operation
// - the bridge is sole ISA master; no bus-master request is accepted
// - refresh output is held permanently high
// - no DMA: seven acknowledges high, requests ignored, terminal count low
// - 8-bit and 16-bit I/O cycles; 16-bit only when module asserts IOCS16
// - I/O is forwarded only when no LPC device claims it
// - I/O 0xC80-0xCBF is kept internal, never forwarded
// - two internal serial ports, enabled at reset at 0x3F8 and 0x2F8
// - each enabled serial port withholds its selectable 8-byte window
// - three configurable LPC I/O regions claim accesses when enabled
// - memory 0xD0000-0xDFFFF forwarded when enabled; nothing else
// - only ISA interrupts 3,4,5,6,7,9,10,11,12,15 reach the host
// - each interrupt is disabled at reset until its enable is set
// - everything runs from the single LPC-rate clock
`timescale 1ns/1ps
`include "bridge_consts.svh"
module lpc_isa_bridge (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // wishbone slave
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [7:0]           adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    output logic      [31:0]          dat_o,
    output logic                      ack_o,
    // host request port
    input  wire logic                 host_req_i,
    input  wire logic                 host_io_i,
    input  wire logic                 host_we_i,
    input  wire logic                 host_wide_i,
    input  wire logic [19:0]          host_addr_i,
    input  wire logic [15:0]          host_wdata_i,
    input  wire logic                 lpc_claim_i,
    output logic                      host_busy_o,
    output logic                      host_done_o,
    output logic                      host_fwd_o,
    output logic [15:0]               host_rdata_o,
    output bridge_pkg::irq_vec_t      host_irq_o,
    // isa bus
    output logic [19:0]               isa_addr_o,
    output logic                      isa_sbhe_n_o,
    output logic                      isa_bale_o,
    output logic                      isa_ior_n_o,
    output logic                      isa_iow_n_o,
    output logic                      isa_memr_n_o,
    output logic                      isa_memw_n_o,
    output logic [15:0]               isa_data_o,
    output logic                      isa_data_oe_o,
    input  wire logic [15:0]          isa_data_i,
    input  wire logic                 isa_iocs16_n_i,
    input  wire logic                 isa_iochrdy_i,
    input  wire bridge_pkg::irq_vec_t isa_irq_i,
    output logic                      isa_aen_o,
    output logic                      isa_refresh_n_o,
    output logic [6:0]                isa_dack_n_o,
    output logic                      isa_tc_o
);
    import bridge_pkg::*;

    typedef struct packed {
        state_t          state;
        logic [7:0]      cnt;
        logic            ack;
        logic [31:0]     wb_dat;
        logic [15:0]     ctrl;
        irq_vec_t        irq_en;
        logic [2:0][31:0] rgn;
        logic [11:0]     sy1;
        logic [11:0]     sy2;
        logic [11:0]     sy3;
        logic [11:0]     stab;
        logic [19:0]     haddr;
        logic [15:0]     wdata;
        logic            we;
        logic            io;
        logic            wide;
        logic            split;
        logic            second;
        logic [15:0]     rdata;
        logic            done;
        logic            fwd;
        logic            busy;
        logic [19:0]     isa_addr;
        logic            sbhe_n;
        logic            bale;
        logic            ior_n;
        logic            iow_n;
        logic            memr_n;
        logic            memw_n;
        logic [15:0]     sd;
        logic            sd_oe;
        irq_vec_t        irq;
    } st_t;

    st_t st_reg;
    st_t st_next;

    logic        own_hit;
    logic        coma_hit;
    logic        comb_hit;
    logic [15:0] coma_base;
    logic [15:0] comb_base;
    logic [2:0]  rgn_hit;
    logic        mem_hit;
    logic        io_claim;
    logic        wb_wr;

    function automatic logic [15:0] com_base(input logic [3:0] s);
        case (s)
            4'h0:    com_base = `COM_BASE_0;
            4'h1:    com_base = `COM_BASE_1;
            4'h2:    com_base = `COM_BASE_2;
            4'h3:    com_base = `COM_BASE_3;
            4'h4:    com_base = `COM_BASE_4;
            4'h5:    com_base = `COM_BASE_5;
            4'h6:    com_base = `COM_BASE_6;
            4'h7:    com_base = `COM_BASE_7;
            4'h9:    com_base = `COM_BASE_9;
            default: com_base = `COM_BASE_8;
        endcase
    endfunction

    // address decode of the incoming host request
    always_comb begin
        own_hit  = host_addr_i[15:0] >= `OWN_LO &&
                   host_addr_i[15:0] <= `OWN_HI;
        coma_base = com_base(st_reg.ctrl[`CTRL_COMA_LSB +: 4]);
        comb_base = com_base(st_reg.ctrl[`CTRL_COMB_LSB +: 4]);
        coma_hit = st_reg.ctrl[`CTRL_COMA_EN] &&
                   host_addr_i[15:3] == coma_base[15:3];
        comb_hit = st_reg.ctrl[`CTRL_COMB_EN] &&
                   host_addr_i[15:3] == comb_base[15:3];
        for (int i = 0; i < 3; i++) begin
            rgn_hit[i] = st_reg.rgn[i][`RGN_EN] &&
                ((host_addr_i[15:0] ^ st_reg.rgn[i][15:0]) &
                 ~{8'h00, st_reg.rgn[i][`RGN_MASK_LSB +: 8]}) == 16'h0000;
        end
        mem_hit  = st_reg.ctrl[`CTRL_MEM_EN] && host_addr_i >= `MEM_LO &&
                   host_addr_i <= `MEM_HI;
        io_claim = lpc_claim_i || own_hit || coma_hit || comb_hit ||
                   (|rgn_hit);
        wb_wr    = cyc_i && stb_i && we_i && st_reg.ack;
    end

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        // wishbone: ack one cycle after the request, write lands on the clock edge that ends ack
        st_next.ack = cyc_i && stb_i && !st_reg.ack;
        if (cyc_i && stb_i && !st_reg.ack) begin
            case (adr_i)
                `REG_CTRL:   st_next.wb_dat = {16'h0000, st_reg.ctrl};
                `REG_IRQ_EN: st_next.wb_dat = {22'h000000, st_reg.irq_en};
                `REG_RGN0:   st_next.wb_dat = st_reg.rgn[0];
                `REG_RGN1:   st_next.wb_dat = st_reg.rgn[1];
                `REG_RGN2:   st_next.wb_dat = st_reg.rgn[2];
                `REG_STATUS: st_next.wb_dat = {6'h00, st_reg.stab[11:2],
                             13'h0000, st_reg.wide, st_reg.split,
                             st_reg.busy};
                default:     st_next.wb_dat = 32'h00000000;
            endcase
        end
        if (wb_wr) begin
            for (int b = 0; b < 4; b++) begin
                if (sel_i[b]) begin
                    if (adr_i == `REG_CTRL && b < 2)
                        st_next.ctrl[b*8 +: 8] = dat_i[b*8 +: 8];
                    if (adr_i == `REG_IRQ_EN && b == 0)
                        st_next.irq_en[7:0] = dat_i[7:0];
                    if (adr_i == `REG_IRQ_EN && b == 1)
                        st_next.irq_en[9:8] = dat_i[9:8];
                    for (int r = 0; r < 3; r++) begin
                        if (adr_i == `REG_RGN0 + 8'(r * 4))
                            st_next.rgn[r][b*8 +: 8] = dat_i[b*8 +: 8];
                    end
                end
            end
        end
        // pin synchronisers: a bit changes once stages two and three agree
        st_next.sy1 = {isa_irq_i, isa_iochrdy_i, isa_iocs16_n_i};
        st_next.sy2 = st_reg.sy1;
        st_next.sy3 = st_reg.sy2;
        for (int k = 0; k < 12; k++) begin
            if (st_reg.sy2[k] == st_reg.sy3[k])
                st_next.stab[k] = st_reg.sy3[k];
        end
        st_next.irq = st_reg.stab[11:2] & st_reg.irq_en;
        case (st_reg.state)
            S_IDLE: begin
                if (host_req_i) begin
                    st_next.haddr  = host_addr_i;
                    st_next.wdata  = host_wdata_i;
                    st_next.we     = host_we_i;
                    st_next.io     = host_io_i;
                    st_next.second = 1'b0;
                    st_next.rdata  = 16'h0000;
                    if (host_io_i ? io_claim : !mem_hit) begin
                        st_next.done = 1'b1;
                        st_next.fwd  = 1'b0;
                    end else begin
                        st_next.busy     = 1'b1;
                        st_next.fwd      = 1'b1;
                        st_next.wide     = host_wide_i;
                        st_next.split    = host_wide_i;
                        st_next.isa_addr = host_addr_i;
                        st_next.sbhe_n   = !(host_wide_i && host_io_i);
                        st_next.bale     = 1'b1;
                        st_next.cnt      = `ADDR_CYC;
                        st_next.state    = S_ADDR;
                    end
                end
            end
            S_ADDR: begin
                st_next.cnt = st_reg.cnt - 8'h01;
                if (st_reg.cnt == 8'h01) begin
                    st_next.bale  = 1'b0;
                    st_next.state = S_CMD;
                    st_next.cnt   = `CMD_CYC;
                    if (st_reg.wide && !st_reg.second) begin
                        // 16-bit only with IOCS16 asserted by the module
                        st_next.split = !(st_reg.io && !st_reg.stab[0]);
                        st_next.sbhe_n = st_reg.io && !st_reg.stab[0] ?
                                         1'b0 : 1'b1;
                    end
                    st_next.sd_oe = st_reg.we;
                    st_next.sd    = st_reg.second ?
                                    {8'h00, st_reg.wdata[15:8]} :
                                    st_reg.wdata;
                    st_next.ior_n  = !(st_reg.io && !st_reg.we);
                    st_next.iow_n  = !(st_reg.io && st_reg.we);
                    st_next.memr_n = !(!st_reg.io && !st_reg.we);
                    st_next.memw_n = !(!st_reg.io && st_reg.we);
                end
            end
            S_CMD: begin
                if (st_reg.cnt != 8'h00)
                    st_next.cnt = st_reg.cnt - 8'h01;
                else if (st_reg.stab[1]) begin
                    if (st_reg.second)
                        st_next.rdata[15:8] = isa_data_i[7:0];
                    else if (st_reg.split)
                        st_next.rdata[7:0] = isa_data_i[7:0];
                    else
                        st_next.rdata = isa_data_i;
                    st_next.ior_n  = 1'b1;
                    st_next.iow_n  = 1'b1;
                    st_next.memr_n = 1'b1;
                    st_next.memw_n = 1'b1;
                    st_next.sd_oe  = 1'b0;
                    st_next.cnt    = `REC_CYC;
                    st_next.state  = S_RECOV;
                end
            end
            S_RECOV: begin
                st_next.cnt = st_reg.cnt - 8'h01;
                if (st_reg.cnt == 8'h01) begin
                    if (st_reg.split && !st_reg.second) begin
                        st_next.second   = 1'b1;
                        st_next.isa_addr = st_reg.haddr + 20'h00001;
                        st_next.sbhe_n   = 1'b1;
                        st_next.bale     = 1'b1;
                        st_next.cnt      = `ADDR_CYC;
                        st_next.state    = S_ADDR;
                    end else begin
                        st_next.done  = 1'b1;
                        st_next.busy  = 1'b0;
                        st_next.state = S_IDLE;
                    end
                end
            end
            default: st_next.state = S_IDLE;
        endcase
        if (rst_i) begin
            st_next = '0;
            st_next.state  = S_IDLE;
            st_next.ctrl   = `CTRL_RST;
            st_next.irq_en = '0;
            st_next.sy1    = 12'h003;
            st_next.sy2    = 12'h003;
            st_next.sy3    = 12'h003;
            st_next.stab   = 12'h003;
            st_next.sbhe_n = 1'b1;
            st_next.ior_n  = 1'b1;
            st_next.iow_n  = 1'b1;
            st_next.memr_n = 1'b1;
            st_next.memw_n = 1'b1;
        end
    end

    // single clock for host, bus and registers
    always_ff @(posedge clk_i) begin
        st_reg <= st_next;
    end

    assign dat_o        = st_reg.wb_dat;
    assign ack_o        = st_reg.ack;
    assign host_busy_o  = st_reg.busy;
    assign host_done_o  = st_reg.done;
    assign host_fwd_o   = st_reg.fwd;
    assign host_rdata_o = st_reg.rdata;
    assign host_irq_o   = st_reg.irq;
    assign isa_addr_o   = st_reg.isa_addr;
    assign isa_sbhe_n_o = st_reg.sbhe_n;
    assign isa_bale_o   = st_reg.bale;
    assign isa_ior_n_o  = st_reg.ior_n;
    assign isa_iow_n_o  = st_reg.iow_n;
    assign isa_memr_n_o = st_reg.memr_n;
    assign isa_memw_n_o = st_reg.memw_n;
    assign isa_data_o   = st_reg.sd;
    assign isa_data_oe_o = st_reg.sd_oe;
    // no dma or refresh master: constant quiet levels
    assign isa_aen_o       = 1'b0;
    assign isa_refresh_n_o = 1'b1;
    assign isa_dack_n_o    = 7'h7F;
    assign isa_tc_o        = 1'b0;

    sequence first_half;
        $fell(st_reg.bale) && st_reg.split && !st_reg.second;
    endsequence
    sequence second_half;
        $fell(st_reg.bale) && st_reg.second;
    endsequence

    chk_refresh_high: assert property (@(posedge clk_i)
        isa_refresh_n_o) else $error("refresh went low");
    chk_dma_quiet: assert property (@(posedge clk_i)
        isa_dack_n_o == 7'h7F && !isa_tc_o) else $error("dma lines active");
    chk_claim_local: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.state == S_IDLE && host_req_i && host_io_i && io_claim
        |=> host_done_o && !host_fwd_o && !host_busy_o)
        else $error("claimed io was forwarded");
    chk_own_range: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(host_busy_o) && st_reg.io |->
        !(st_reg.haddr[15:0] >= `OWN_LO && st_reg.haddr[15:0] <= `OWN_HI))
        else $error("internal range reached isa");
    chk_mem_window: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(isa_memr_n_o) || $fell(isa_memw_n_o) |->
        st_reg.ctrl[`CTRL_MEM_EN] && st_reg.haddr[19:16] == 4'hD)
        else $error("memory outside window");
    chk_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 host_irq_o == ($past(st_reg.stab[11:2]) & $past(st_reg.irq_en)))
        else $error("irq gating wrong");
    chk_reset_defaults: assert property (@(posedge clk_i)
        rst_i |=> st_reg.ctrl == `CTRL_RST && st_reg.irq_en == 10'h000)
        else $error("reset defaults wrong");
    chk_split_two: assert property (@(posedge clk_i) disable iff (rst_i)
        first_half |-> ##[1:300] second_half)
        else $error("split access lost its second byte");
    chk_wide_sbhe: assert property (@(posedge clk_i) disable iff (rst_i)
        !isa_ior_n_o || !isa_iow_n_o |->
        isa_sbhe_n_o == (st_reg.split || !st_reg.wide))
        else $error("sbhe does not match cycle width");
    chk_cmd_width: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(isa_ior_n_o) |-> !isa_ior_n_o [*8])
        else $error("io read strobe too short");
endmodule // lpc_isa_bridge

// File: verification/isa_module_model.sv
// model of the expansion modules on the stacked isa bus
// assumes strobes and address from the bridge, one clock shared with the bench
`timescale 1ns/1ps
module isa_module_model (
    // clock and mode
    input  wire logic        clk_i,
    input  wire logic        slow_i,
    // isa bus from the bridge
    input  wire logic [19:0] addr_i,
    input  wire logic        sbhe_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic [15:0] bus_i,
    // answers to the bridge
    output logic [15:0]      data_o,
    output logic             cs16_n_o,
    output logic             rdy_o
);
    logic [7:0]  store [256];
    logic [15:0] last_reg = 16'h5AA5;
    logic [7:0]  wait_reg = 8'h00;
    logic        idle_prev = 1'b1;
    logic        idle;
    logic        wide;
    int          strobes = 0;

    function automatic logic [7:0] byte_at(input logic [19:0] a);
        return a[7:0] ^ 8'h3C;
    endfunction

    // only the module at 0x300-0x30F is 16-bit capable
    assign wide     = (addr_i[15:4] == 12'h030);
    assign cs16_n_o = !wide;
    assign idle     = rd_n_i && wr_n_i;
    // slow mode holds the cycle for 100 clocks; pulled up otherwise
    assign rdy_o    = !(slow_i && !idle && wait_reg < 8'h64);

    // undriven lanes show the inverse of the last value driven
    always_comb begin
        data_o = ~last_reg;
        if (!rd_n_i) begin
            data_o[7:0] = byte_at(addr_i);
            if (wide) begin
                data_o[15:8] = byte_at(addr_i + 20'h1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        idle_prev <= idle;
        wait_reg  <= idle ? 8'h00 : wait_reg + 8'h01;
        if (!rd_n_i) begin
            last_reg <= data_o;
        end
        if (idle_prev && !idle) begin
            strobes <= strobes + 1;
        end
        if (!wr_n_i) begin
            store[addr_i[7:0]] <= bus_i[7:0];
            if (wide && !sbhe_n_i) begin
                store[addr_i[7:0] + 8'h01] <= bus_i[15:8];
            end
        end
    end
endmodule // isa_module_model

// File: verification/testbench.sv
// self-checking bench for the host-to-isa bridge
// assumes the bridge, its constants header and the isa module model
`timescale 1ns/1ps
`include "bridge_consts.svh"
module testbench;
    import bridge_pkg::*;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic        host_req_i, host_io_i, host_we_i, host_wide_i, lpc_claim_i;
    logic [19:0] host_addr_i, isa_addr_o;
    logic [15:0] host_wdata_i, host_rdata_o, isa_data_o, sd_bus, mod_data;
    logic [15:0] rd;
    logic        host_busy_o, host_done_o, host_fwd_o, fwd, slow;
    irq_vec_t    host_irq_o, isa_irq_i;
    logic        isa_sbhe_n_o, isa_bale_o, isa_ior_n_o, isa_iow_n_o;
    logic        isa_memr_n_o, isa_memw_n_o, isa_data_oe_o, isa_iocs16_n_i;
    logic        isa_iochrdy_i, isa_aen_o, isa_refresh_n_o, isa_tc_o;
    logic [6:0]  isa_dack_n_o;
    logic [15:0] base [9] = '{16'h0200, 16'h0208, 16'h0220, 16'h0228,
                              16'h0238, 16'h02E8, 16'h0338, 16'h03E8, 16'h03F8};
    int          fail_count = 0;
    int          tests_run = 0;
    int          s0;

    lpc_isa_bridge u_dut (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .host_req_i, .host_io_i, .host_we_i, .host_wide_i,
        .host_addr_i, .host_wdata_i, .lpc_claim_i, .host_busy_o,
        .host_done_o, .host_fwd_o, .host_rdata_o, .host_irq_o, .isa_addr_o,
        .isa_sbhe_n_o, .isa_bale_o, .isa_ior_n_o, .isa_iow_n_o,
        .isa_memr_n_o, .isa_memw_n_o, .isa_data_o, .isa_data_oe_o,
        .isa_data_i(sd_bus), .isa_iocs16_n_i, .isa_iochrdy_i, .isa_irq_i,
        .isa_aen_o, .isa_refresh_n_o, .isa_dack_n_o, .isa_tc_o
    );
    assign sd_bus = isa_data_oe_o ? isa_data_o : mod_data;
    isa_module_model u_isa (
        .clk_i, .slow_i(slow), .addr_i(isa_addr_o), .sbhe_n_i(isa_sbhe_n_o),
        .rd_n_i(isa_ior_n_o & isa_memr_n_o),
        .wr_n_i(isa_iow_n_o & isa_memw_n_o),
        .bus_i(sd_bus), .data_o(mod_data), .cs16_n_o(isa_iocs16_n_i),
        .rdy_o(isa_iochrdy_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        r = dat_o;
        if (ack_o !== 1'b1) begin
            fail_count++;
            wrap_up();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic host(input logic io, input logic w, input logic wd,
                        input logic [19:0] a, input logic [15:0] d);
        int n = 0;
        host_req_i   <= 1'b1;
        host_io_i    <= io;
        host_we_i    <= w;
        host_wide_i  <= wd;
        host_addr_i  <= a;
        host_wdata_i <= d;
        @(posedge clk_i);
        host_req_i <= 1'b0;
        do begin
            @(posedge clk_i);
            n++;
        end while (host_done_o !== 1'b1 && n < 3000);
        fwd = host_fwd_o;
        rd  = host_rdata_o;
        if (host_done_o !== 1'b1) begin
            fail_count++;
            wrap_up();
        end
        @(posedge clk_i);
    endtask

    task automatic io_chk(input logic [19:0] a, input logic e);
        host(1'b1, 1'b0, 1'b0, a, 16'h0000);
        check_val(32'(fwd), 32'(e));
    endtask

    task automatic t_static();
        check_val(32'(isa_aen_o), 32'h0);
        check_val(32'(isa_refresh_n_o), 32'h1);
        check_val(32'(isa_dack_n_o), 32'h7F);
        check_val(32'(isa_tc_o), 32'h0);
    endtask

    task automatic t_regs();
        wb(1'b0, `REG_CTRL, 32'h0, q);
        check_val(q & 32'h0FFF, 32'h0983);
        wb(1'b0, `REG_IRQ_EN, 32'h0, q);
        check_val(q, 32'h0);
        wb(1'b0, 8'h1C, 32'h0, q);
        check_val(q, 32'h0);
    endtask

    task automatic t_decode();
        io_chk(20'h00C80, 1'b0);
        io_chk(20'h00CBF, 1'b0);
        io_chk(20'h00C7F, 1'b1);
        io_chk(20'h00CC0, 1'b1);
        io_chk(20'h003F8, 1'b0);
        io_chk(20'h003FF, 1'b0);
        io_chk(20'h002F8, 1'b0);
        io_chk(20'h002FF, 1'b0);
        lpc_claim_i <= 1'b1;
        io_chk(20'h00300, 1'b0);
        lpc_claim_i <= 1'b0;
        io_chk(20'h00300, 1'b1);
    endtask

    task automatic t_irq();
        isa_irq_i <= 10'h3FF;
        repeat (10) @(posedge clk_i);
        check_val(32'(host_irq_o), 32'h0);
        wb(1'b1, `REG_IRQ_EN, 32'h205, q);
        repeat (10) @(posedge clk_i);
        check_val(32'(host_irq_o), 32'h205);
        isa_irq_i <= 10'h004;
        repeat (10) @(posedge clk_i);
        check_val(32'(host_irq_o), 32'h004);
        wb(1'b0, `REG_STATUS, 32'h0, q);
        check_val(q & 32'h03FF0001, 32'h00040000);
    endtask

    task automatic t_memory();
        wb(1'b1, `REG_CTRL, 32'h0983, q);
        host(1'b0, 1'b0, 1'b0, 20'hD0010, 16'h0000);
        check_val(32'(fwd), 32'h0);
        wb(1'b1, `REG_CTRL, 32'h1983, q);
        host(1'b0, 1'b0, 1'b0, 20'hD0010, 16'h0000);
        check_val({31'h0, fwd}, 32'h1);
        check_val(32'(rd[7:0]), 32'h2C);
        host(1'b0, 1'b0, 1'b0, 20'hDFFFF, 16'h0000);
        check_val({23'h0, fwd, rd[7:0]}, 32'h1C3);
        host(1'b0, 1'b1, 1'b1, 20'hD0020, 16'h5678);
        check_val({16'h0, u_isa.store[33], u_isa.store[32]}, 32'h5678);
        host(1'b0, 1'b0, 1'b0, 20'hE0000, 16'h0000);
        check_val(32'(fwd), 32'h0);
        host(1'b0, 1'b0, 1'b0, 20'hCFFFF, 16'h0000);
        check_val(32'(fwd), 32'h0);
    endtask

    task automatic t_com();
        wb(1'b1, `REG_CTRL, 32'h1903, q);
        io_chk(20'h00208, 1'b1);
        for (int k = 0; k < 9; k++) begin
            wb(1'b1, `REG_CTRL, 32'h1903 | (k << 4), q);
            io_chk({4'h0, base[k] + 16'h0007}, 1'b0);
        end
        wb(1'b1, `REG_CTRL, 32'h1902, q);
        io_chk(20'h00207, 1'b1);
    endtask

    task automatic t_regions();
        io_chk(20'h00380, 1'b1);
        for (int n = 0; n < 3; n++) begin
            wb(1'b1, `REG_RGN0 + 8'(4 * n), 32'h8003_0380 + 32'(16 * n), q);
            io_chk(20'h00383 + 20'(16 * n), 1'b0);
        end
        io_chk(20'h00384, 1'b1);
    endtask

    task automatic t_width();
        s0 = u_isa.strobes;
        host(1'b1, 1'b0, 1'b1, 20'h00302, 16'h0000);
        check_val({16'h0, rd}, 32'h3F3E);
        check_val(32'(u_isa.strobes - s0), 32'h1);
        slow <= 1'b1;
        s0 = u_isa.strobes;
        host(1'b1, 1'b0, 1'b1, 20'h00310, 16'h0000);
        check_val({16'h0, rd}, 32'h2D2C);
        check_val(32'(u_isa.strobes - s0), 32'h2);
        slow <= 1'b0;
        host(1'b1, 1'b1, 1'b1, 20'h00304, 16'h1234);
        check_val({16'h0, u_isa.store[5], u_isa.store[4]}, 32'h1234);
        host(1'b1, 1'b1, 1'b1, 20'h00312, 16'hABCD);
        check_val({16'h0, u_isa.store[19], u_isa.store[18]}, 32'hABCD);
    endtask

    initial begin
        rst_i        = 1'b1;
        cyc_i        = 1'b0;
        stb_i        = 1'b0;
        we_i         = 1'b0;
        adr_i        = 8'h00;
        sel_i        = 4'h0;
        dat_i        = 32'h0;
        host_req_i   = 1'b0;
        host_io_i    = 1'b0;
        host_we_i    = 1'b0;
        host_wide_i  = 1'b0;
        host_addr_i  = 20'h0;
        host_wdata_i = 16'h0;
        lpc_claim_i  = 1'b0;
        isa_irq_i    = '0;
        slow         = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_static();
        t_regs();
        t_decode();
        t_irq();
        t_memory();
        t_com();
        t_regions();
        t_width();
        t_static();
        wrap_up();
    end
endmodule // testbench
